// [cdt_ctrl.sv]
// Host controller that programs and sequences the cascadable dual timer
`timescale 1ns/1ps
module cdt_ctrl
	import cdt_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic [SW_AW-1:0] sw_addr_i,
	input wire logic [SW_DW-1:0] sw_wdata_i,
	input wire logic sw_wr_i,
	input wire logic sw_rd_i,
	output logic [SW_DW-1:0] sw_rdata_o,
	output logic [7:0] dev_addr_o,
	output logic [7:0] dev_wdata_o,
	output logic dev_wr_o,
	input wire logic [1:0] tmr_match_i
);
	cdt_state_t state_r, state_nxt;
	logic [15:0] period_r, duty_r;
	logic slow_r, supp_r;
	logic [1:0] run_r;
	logic act_unit_r, act_wide_r;
	logic [2:0] mode_r [2];
	logic [2:0] clk_r [2];
	logic tff_r [2];
	logic [3:0] err_r;
	logic [1:0] m1_r, m2_r, m3_r;
	logic [7:0] cnt_r [2];
	logic [7:0] wr_addr_w, wr_data_w;

	cdt_chk_if chk_if ();

	cdt_check u_check (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.chk(chk_if.chk)
	);

	// Software command decode
	wire logic wr_cmd_w = sw_wr_i && sw_addr_i == SW_CMD;
	wire logic go_w = wr_cmd_w && sw_wdata_i[CMD_GO_BIT];
	wire logic stop_req_w = wr_cmd_w && sw_wdata_i[CMD_STOP_BIT] && !sw_wdata_i[CMD_GO_BIT];
	wire logic [2:0] cmd_mode_w = sw_wdata_i[CMD_MODE_LSB +: 3];
	wire logic [2:0] cmd_clk_w = sw_wdata_i[CMD_CLK_LSB +: 3];
	wire logic cmd_tff_w = sw_wdata_i[CMD_TFF_BIT];
	wire logic cmd_wide_w = cmd_mode_w[2];
	// Wide modes always act through the upper unit's run and flip-flop control
	wire logic cmd_unit_w = cmd_wide_w | sw_wdata_i[CMD_UNIT_BIT];
	wire logic idle_w = state_r == ST_IDLE;
	wire logic unit_busy_w = cmd_wide_w ? |run_r : run_r[cmd_unit_w];
	// Starting a running unit is refused so its settings never move mid-run
	wire logic go_ok_w = go_w && idle_w && !unit_busy_w;
	wire logic start_w = go_ok_w && chk_if.clk_ok && chk_if.val_ok && chk_if.tff_ok;
	wire logic stop_unit_w = (run_r[1] && act_wide_r) | sw_wdata_i[CMD_UNIT_BIT];
	wire logic stop_w = stop_req_w && idle_w && run_r[stop_unit_w];
	wire logic reg_wr_w = sw_wr_i && (sw_addr_i == SW_PERIOD || sw_addr_i == SW_DUTY);
	wire logic busy_hit_w = (go_w && !go_ok_w) || ((reg_wr_w || stop_req_w) && !idle_w);
	wire logic [3:0] err_set_w = {busy_hit_w, go_ok_w && !chk_if.tff_ok,
		go_ok_w && !chk_if.val_ok, go_ok_w && !chk_if.clk_ok};
	wire logic [3:0] err_clr_w = (sw_wr_i && sw_addr_i == SW_STATUS) ?
		sw_wdata_i[ST_ERR_CLK_BIT +: 4] : 4'h0;
	wire logic [1:0] edge_w = m2_r & ~m3_r;
	wire logic cnt_clr_w = sw_wr_i && sw_addr_i == SW_MATCH;

	assign chk_if.slow = slow_r;
	assign chk_if.mode = cmd_mode_w;
	assign chk_if.clk = cmd_clk_w;
	assign chk_if.tff = cmd_tff_w;
	assign chk_if.period = period_r;
	assign chk_if.duty = duty_r;

	// Device register write selection
	wire logic lo_target_w = act_wide_r || !act_unit_r;
	wire logic [7:0] ctl_addr_w = act_unit_r ? DEV_CTL_UP : DEV_CTL_LO;
	wire logic [7:0] run_byte_w = ctl_byte(1'b1, tff_r[act_unit_r], clk_r[act_unit_r],
		mode_r[act_unit_r]);
	wire logic [7:0] stop_byte_w = ctl_byte(1'b0, tff_r[act_unit_r], clk_r[act_unit_r],
		mode_r[act_unit_r]);

	always_comb begin
		wr_addr_w = 8'h00;
		wr_data_w = 8'h00;
		state_nxt = state_r;
		unique case (state_r)
			ST_IDLE: begin
				if (start_w) begin
					state_nxt = ST_TT_LO;
				end else if (stop_w) begin
					state_nxt = ST_STOP;
				end
			end
			// Compare values go out only while the unit is stopped
			ST_TT_LO: begin
				wr_addr_w = lo_target_w ? DEV_TT_LO : DEV_TT_UP;
				wr_data_w = period_r[7:0];
				state_nxt = act_wide_r ? ST_TT_HI : ST_PW_LO;
			end
			ST_TT_HI: begin
				wr_addr_w = DEV_TT_UP;
				wr_data_w = period_r[15:8];
				state_nxt = ST_PW_LO;
			end
			ST_PW_LO: begin
				wr_addr_w = lo_target_w ? DEV_PW_LO : DEV_PW_UP;
				wr_data_w = duty_r[7:0];
				state_nxt = act_wide_r ? ST_PW_HI : ST_AUX;
			end
			ST_PW_HI: begin
				wr_addr_w = DEV_PW_UP;
				wr_data_w = duty_r[15:8];
				state_nxt = ST_AUX;
			end
			// Limitation: other aux bits are written as zero
			ST_AUX: begin
				wr_addr_w = DEV_AUX;
				wr_data_w = supp_r ? AUX_SUPP_MASK : 8'h00;
				state_nxt = act_wide_r ? ST_CTL_LO : ST_CTL;
			end
			ST_CTL_LO: begin
				wr_addr_w = DEV_CTL_LO;
				wr_data_w = ctl_byte(1'b0, 1'b0, clk_r[1], MODE_CASCADE);
				state_nxt = ST_CTL;
			end
			ST_CTL: begin
				wr_addr_w = ctl_addr_w;
				wr_data_w = run_byte_w;
				state_nxt = ST_IDLE;
			end
			ST_STOP: begin
				wr_addr_w = ctl_addr_w;
				wr_data_w = stop_byte_w;
				state_nxt = ST_IDLE;
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			state_r <= ST_IDLE;
			dev_wr_o <= 1'b0;
			dev_addr_o <= 8'h00;
			dev_wdata_o <= 8'h00;
		end else begin
			state_r <= state_nxt;
			dev_wr_o <= state_r != ST_IDLE;
			dev_addr_o <= wr_addr_w;
			dev_wdata_o <= wr_data_w;
		end
	end

	// Per-unit settings change only on an accepted start
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			act_unit_r <= 1'b0;
			act_wide_r <= 1'b0;
			mode_r <= '{MODE_TIMER, MODE_TIMER};
			clk_r <= '{CLK_SLOWEST, CLK_SLOWEST};
			tff_r <= '{1'b0, 1'b0};
		end else if (start_w) begin
			act_unit_r <= cmd_unit_w;
			act_wide_r <= cmd_wide_w;
			mode_r[cmd_unit_w] <= cmd_mode_w;
			clk_r[cmd_unit_w] <= cmd_clk_w;
			tff_r[cmd_unit_w] <= cmd_tff_w;
		end else if (stop_w) begin
			act_unit_r <= stop_unit_w;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			run_r <= 2'h0;
		end else if (state_r == ST_CTL) begin
			run_r <= act_wide_r ? 2'h3 : (run_r | (act_unit_r ? 2'h2 : 2'h1));
		end else if (state_r == ST_STOP) begin
			run_r <= act_wide_r ? 2'h0 : (run_r & (act_unit_r ? 2'h1 : 2'h2));
		end
	end

	// Values held here; all but slow_r pushed to the device only at start
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			period_r <= PERIOD_RST;
			duty_r <= DUTY_RST;
			slow_r <= 1'b0;
			supp_r <= 1'b0;
		end else if (sw_wr_i && idle_w) begin
			if (sw_addr_i == SW_PERIOD) begin
				period_r <= sw_wdata_i;
			end
			if (sw_addr_i == SW_DUTY) begin
				duty_r <= sw_wdata_i;
			end
			if (sw_addr_i == SW_POWER) begin
				slow_r <= sw_wdata_i[PWR_SLOW_BIT];
				supp_r <= sw_wdata_i[PWR_SUPP_BIT];
			end
		end
	end

	// Sticky errors; a new error beats a clear in the same cycle
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			err_r <= 4'h0;
		end else begin
			err_r <= (err_r & ~err_clr_w) | err_set_w;
		end
	end

	// Match pins come from the device's clock, so two stages before use
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			m1_r <= 2'h0;
			m2_r <= 2'h0;
			m3_r <= 2'h0;
		end else begin
			m1_r <= tmr_match_i;
			m2_r <= m1_r;
			m3_r <= m2_r;
		end
	end

	for (genvar u = 0; u < 2; u++) begin : g_cnt
		always_ff @(posedge ref_clk_i) begin
			if (rst_i) begin
				cnt_r[u] <= COUNT_RST;
			end else if (cnt_clr_w) begin
				cnt_r[u] <= edge_w[u] ? 8'h01 : COUNT_RST;
			end else if (edge_w[u]) begin
				cnt_r[u] <= cnt_r[u] + 8'h01;
			end
		end
	end

	wire logic [15:0] cmd_rb_w = {6'h00, tff_r[act_unit_r], clk_r[act_unit_r],
		mode_r[act_unit_r], act_unit_r, 2'h0};
	wire logic [15:0] status_w = {8'h00, err_r, act_wide_r, run_r, !idle_w};
	wire logic [15:0] rd_mux_w = sw_addr_i == SW_CMD ? cmd_rb_w :
		sw_addr_i == SW_PERIOD ? period_r :
		sw_addr_i == SW_DUTY ? duty_r :
		sw_addr_i == SW_POWER ? {14'h0000, supp_r, slow_r} :
		sw_addr_i == SW_STATUS ? status_w :
		sw_addr_i == SW_MATCH ? {cnt_r[1], cnt_r[0]} : 16'h0000;

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			sw_rdata_o <= 16'h0000;
		end else begin
			sw_rdata_o <= sw_rd_i ? rd_mux_w : 16'h0000;
		end
	end

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);

	run_edit_a: assert property (
		dev_wr_o && dev_addr_o == DEV_CTL_UP && $past(run_r[1]) |-> !dev_wdata_o[CTL_RUN_BIT])
		else $error("upper control rewritten while running");
	stop_keep_a: assert property (
		dev_wr_o && dev_addr_o == DEV_CTL_UP && $past(run_r[1])
		|-> dev_wdata_o == ctl_byte(1'b0, tff_r[1], clk_r[1], mode_r[1]))
		else $error("stop write altered settings");
	// Compare and aux bytes can carry bit 3 too, so only control addresses count
	start_load_a: assert property (
		start_w |-> ##[5:8] (dev_wr_o && (dev_addr_o == DEV_CTL_LO || dev_addr_o == DEV_CTL_UP)
		&& dev_wdata_o[CTL_RUN_BIT]))
		else $error("start write missing");
	lower_cas_a: assert property (
		dev_wr_o && dev_addr_o == DEV_CTL_LO && act_wide_r |-> dev_wdata_o[2:0] == MODE_CASCADE)
		else $error("lower mode not cascade in wide mode");
	clk_refuse_a: assert property (
		go_ok_w && !chk_if.clk_ok |=> state_r == ST_IDLE && err_r[0])
		else $error("illegal clock not refused");
	val_refuse_a: assert property (
		go_ok_w && !chk_if.val_ok |=> state_r == ST_IDLE ##1 !dev_wr_o)
		else $error("illegal compare value not refused");
	tff_zero_a: assert property (
		dev_wr_o && (dev_addr_o == DEV_CTL_LO || dev_addr_o == DEV_CTL_UP)
		&& dev_wdata_o[CTL_RUN_BIT] && (dev_wdata_o[2:0] == MODE_TIMER
		|| dev_wdata_o[2:0] == MODE_T16) |-> !dev_wdata_o[CTL_TFF_BIT])
		else $error("flip-flop control set in timer mode");
	reg_stopped_a: assert property (
		dev_wr_o && (dev_addr_o == DEV_TT_LO || dev_addr_o == DEV_PW_LO) |-> !run_r[0])
		else $error("compare register written while running");

	start8_c: cover property (start_w && !cmd_wide_w ##5 dev_wr_o);
	start16_c: cover property (start_w && cmd_wide_w ##8 run_r == 2'h3);
	stop_c: cover property (stop_w ##2 dev_wr_o && !dev_wdata_o[CTL_RUN_BIT]);
	match_c: cover property (edge_w[1] && run_r[1]);
endmodule

// [cdt_pkg.sv]
// Constants, codes and helpers shared by the cascaded timer controller
package cdt_pkg;
	// Software-side port
	localparam int SW_AW = 3;
	localparam int SW_DW = 16;
	localparam logic [2:0] SW_CMD = 3'h0;
	localparam logic [2:0] SW_PERIOD = 3'h1;
	localparam logic [2:0] SW_DUTY = 3'h2;
	localparam logic [2:0] SW_POWER = 3'h3;
	localparam logic [2:0] SW_STATUS = 3'h4;
	localparam logic [2:0] SW_MATCH = 3'h5;
	// Command word fields
	localparam int CMD_GO_BIT = 0;
	localparam int CMD_STOP_BIT = 1;
	localparam int CMD_UNIT_BIT = 2;
	localparam int CMD_MODE_LSB = 3;
	localparam int CMD_CLK_LSB = 6;
	localparam int CMD_TFF_BIT = 9;
	// Power word fields
	localparam int PWR_SLOW_BIT = 0;
	localparam int PWR_SUPP_BIT = 1;
	// Status word fields (bits 4..7 are write-one-to-clear)
	localparam int ST_ERR_CLK_BIT = 4;
	localparam int ST_ERR_VAL_BIT = 5;
	localparam int ST_ERR_TFF_BIT = 6;
	localparam int ST_ERR_BUSY_BIT = 7;
	// Reset values
	localparam logic [15:0] PERIOD_RST = 16'h0000;
	localparam logic [15:0] DUTY_RST = 16'h0000;
	localparam logic [7:0] COUNT_RST = 8'h00;
	// Device register addresses
	localparam logic [7:0] DEV_CTL_LO = 8'h1A;
	localparam logic [7:0] DEV_CTL_UP = 8'h1B;
	localparam logic [7:0] DEV_TT_LO = 8'h1C;
	localparam logic [7:0] DEV_TT_UP = 8'h1D;
	localparam logic [7:0] DEV_PW_LO = 8'h1E;
	localparam logic [7:0] DEV_PW_UP = 8'h1F;
	localparam logic [7:0] DEV_AUX = 8'h19;
	// Device control byte layout
	localparam int CTL_RUN_BIT = 3;
	localparam int CTL_TFF_BIT = 7;
	localparam logic [7:0] AUX_SUPP_MASK = 8'h08;
	// Mode field codes
	localparam logic [2:0] MODE_TIMER = 3'h0;
	localparam logic [2:0] MODE_PDO = 3'h1;
	localparam logic [2:0] MODE_PWM = 3'h2;
	localparam logic [2:0] MODE_CASCADE = 3'h3;
	localparam logic [2:0] MODE_T16 = 3'h4;
	localparam logic [2:0] MODE_WARM = 3'h5;
	localparam logic [2:0] MODE_PWM16 = 3'h6;
	localparam logic [2:0] MODE_PPG = 3'h7;
	// Clock select codes
	localparam logic [2:0] CLK_SLOWEST = 3'h0;
	localparam logic [2:0] CLK_D8 = 3'h3;
	localparam logic [2:0] CLK_LOW = 3'h4;
	localparam logic [2:0] CLK_HIGH = 3'h6;
	localparam logic [2:0] CLK_PIN = 3'h7;
	// Compare limits
	localparam logic [15:0] LIM_ONE = 16'h0001;
	localparam logic [15:0] LIM8_MAX = 16'h00FF;
	localparam logic [15:0] PWM8_MIN = 16'h0002;
	localparam logic [15:0] PWM8_MAX = 16'h00FE;
	localparam logic [15:0] WARM_MIN = 16'h0100;
	localparam logic [15:0] PWM16_MAX = 16'hFFFE;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_TT_LO = 4'h1,
		ST_TT_HI = 4'h2,
		ST_PW_LO = 4'h3,
		ST_PW_HI = 4'h4,
		ST_AUX = 4'h5,
		ST_CTL_LO = 4'h6,
		ST_CTL = 4'h7,
		ST_STOP = 4'h8
	} cdt_state_t;

	function automatic logic [7:0] ctl_byte(input logic run, input logic tff,
		input logic [2:0] clk, input logic [2:0] mode);
		return {tff, clk, run, mode};
	endfunction
endpackage

// [cdt_chk_if.sv]
// Carrier between the sequencer and the legality checker
`timescale 1ns/1ps
interface cdt_chk_if;
	logic slow;
	logic [2:0] mode;
	logic [2:0] clk;
	logic tff;
	logic [15:0] period;
	logic [15:0] duty;
	logic clk_ok;
	logic val_ok;
	logic tff_ok;
	modport seq (output slow, mode, clk, tff, period, duty, input clk_ok, val_ok, tff_ok);
	modport chk (input slow, mode, clk, tff, period, duty, output clk_ok, val_ok, tff_ok);
endinterface

// [cdt_check.sv]
// Legality of a requested mode, source clock and compare values
`timescale 1ns/1ps
module cdt_check
	import cdt_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic rst_i,
	cdt_chk_if.chk chk
);
	wire logic fast_tap_w;
	wire logic [16:0] duty_inc_w;

	assign fast_tap_w = chk.clk <= CLK_D8;
	assign duty_inc_w = {1'b0, chk.duty} + 17'h00001;

	// Clock legality per mode and power mode
	always_comb begin
		unique case (chk.mode)
			MODE_TIMER, MODE_T16: chk.clk_ok = chk.slow ?
				(chk.clk == CLK_SLOWEST || chk.clk == CLK_PIN) : (fast_tap_w || chk.clk == CLK_PIN);
			MODE_PDO: chk.clk_ok = chk.slow ? (chk.clk == CLK_SLOWEST) : fast_tap_w;
			MODE_PWM: chk.clk_ok = chk.slow ?
				(chk.clk == CLK_SLOWEST || chk.clk == CLK_LOW) : (chk.clk != CLK_PIN);
			MODE_WARM: chk.clk_ok = chk.slow ? (chk.clk == CLK_HIGH) : (chk.clk == CLK_LOW);
			MODE_PWM16: chk.clk_ok = chk.slow ? (chk.clk == CLK_SLOWEST || chk.clk == CLK_LOW
				|| chk.clk == CLK_PIN) : 1'b1;
			MODE_PPG: chk.clk_ok = chk.slow ?
				(chk.clk == CLK_SLOWEST || chk.clk == CLK_PIN) : (fast_tap_w || chk.clk == CLK_PIN);
			MODE_CASCADE: chk.clk_ok = 1'b0;
		endcase
	end

	// Compare value legality per mode
	always_comb begin
		unique case (chk.mode)
			MODE_TIMER, MODE_PDO: chk.val_ok = chk.period >= LIM_ONE && chk.period <= LIM8_MAX;
			MODE_PWM: chk.val_ok = chk.duty >= PWM8_MIN && chk.duty <= PWM8_MAX;
			MODE_T16: chk.val_ok = chk.period >= LIM_ONE;
			MODE_WARM: chk.val_ok = chk.period >= WARM_MIN;
			MODE_PWM16: chk.val_ok = chk.duty >= PWM8_MIN && chk.duty <= PWM16_MAX;
			MODE_PPG: chk.val_ok = chk.duty >= LIM_ONE && duty_inc_w < {1'b0, chk.period};
			MODE_CASCADE: chk.val_ok = 1'b0;
		endcase
	end

	// Plain timer and event counter keep the flip-flop control low
	assign chk.tff_ok = !((chk.mode == MODE_TIMER || chk.mode == MODE_T16) && chk.tff);

	warm_floor_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		chk.mode == MODE_WARM && chk.period < WARM_MIN |-> !chk.val_ok)
		else $error("warm-up period below floor accepted");
	pwm16_span_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		chk.mode == MODE_PWM16 && (chk.duty == 16'hFFFF || chk.duty < PWM8_MIN) |-> !chk.val_ok)
		else $error("16-bit duty out of range accepted");
	ppg_gap_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		chk.mode == MODE_PPG && chk.val_ok |-> chk.duty != 16'h0000 && chk.duty < chk.period - 16'h0001)
		else $error("pulse generator duty gap violated");
endmodule

// [cdt_dev_model.sv]
// Behavioural model of the cascadable dual timer device
`timescale 1ns/1ps
module cdt_dev_model
	import cdt_pkg::*;
#(
	parameter logic TAP_SEL = 1'b0,
	parameter logic SLOW_PWR = 1'b0
)
(
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic [7:0] dev_addr_i,
	input wire logic [7:0] dev_wdata_i,
	input wire logic dev_wr_i,
	output logic [1:0] tmr_match_o,
	output logic [7:0] viol_o
);
	logic [7:0] ctl_r [2];
	logic [7:0] tt_r [2];
	logic [7:0] pw_r [2];
	logic [7:0] aux_r;
	logic [7:0] cnt_r [2];
	logic [10:0] pre_r;
	wire u = dev_addr_i[0];
	wire wide = ctl_r[1][2];
	wire is_ctl = dev_wr_i && dev_addr_i[7:1] == DEV_CTL_LO[7:1];
	wire is_tt = dev_wr_i && dev_addr_i[7:1] == DEV_TT_LO[7:1];
	wire is_pw = dev_wr_i && dev_addr_i[7:1] == DEV_PW_LO[7:1];
	wire run_u = ctl_r[u][CTL_RUN_BIT] || (wide && ctl_r[1][CTL_RUN_BIT]);
	wire same = {dev_wdata_i[7:4], dev_wdata_i[2:0]} == {ctl_r[u][7:4], ctl_r[u][2:0]};
	// Counted, not fatal: the host is judged by the bench
	wire bad = (is_ctl && ctl_r[u][CTL_RUN_BIT] && !same) || (is_tt && run_u);
	wire [2:0] clk_lo = ctl_r[0][6:4];
	wire [2:0] clk_up = ctl_r[1][6:4];
	wire run_lo = ctl_r[0][CTL_RUN_BIT] && !wide;
	wire run_up = ctl_r[1][CTL_RUN_BIT];
	// Slowest tap: high clock / 2^11, or low clock / 8 with tap select or slow power
	// Limitation: other sources except the pin run at the bench clock to keep runs short
	wire slow_tick = (TAP_SEL || SLOW_PWR) ? (pre_r[2:0] == 3'h7) : (pre_r == 11'h7FF);
	wire [2:0] src_up = wide ? clk_lo : clk_up;
	// Pin source is left undriven here, so it never ticks
	wire tick_lo = run_lo && clk_lo != CLK_PIN && (clk_lo != CLK_SLOWEST || slow_tick);
	wire tick_up = run_up && src_up != CLK_PIN && (src_up != CLK_SLOWEST || slow_tick);
	wire [15:0] cnt16 = {cnt_r[1], cnt_r[0]};
	wire [15:0] inc16 = cnt16 + 16'h0001;
	wire [7:0] inc_lo = cnt_r[0] + 8'h01;
	wire [7:0] inc_up = cnt_r[1] + 8'h01;
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < 2; i++) begin
				ctl_r[i] <= 8'h00;
				tt_r[i] <= 8'h00;
				pw_r[i] <= 8'h00;
				cnt_r[i] <= 8'h00;
			end
			aux_r <= 8'h00;
			pre_r <= 11'h000;
			tmr_match_o <= 2'h0;
			viol_o <= 8'h00;
		end else begin
			tmr_match_o <= 2'h0;
			pre_r <= pre_r + 11'h001;
			if (is_ctl) ctl_r[u] <= dev_wdata_i;
			if (is_tt) tt_r[u] <= dev_wdata_i;
			if (is_pw) pw_r[u] <= dev_wdata_i;
			if (dev_wr_i && dev_addr_i == DEV_AUX) aux_r <= dev_wdata_i;
			if (bad) viol_o <= viol_o + 8'h01;
			if (wide) begin
				if (!run_up) begin
					cnt_r[0] <= 8'h00;
					cnt_r[1] <= 8'h00;
				end else if (tick_up && inc16 == {tt_r[1], tt_r[0]}) begin
					cnt_r[0] <= 8'h00;
					cnt_r[1] <= 8'h00;
					tmr_match_o[1] <= 1'b1;
				end else if (tick_up) begin
					cnt_r[0] <= inc16[7:0];
					cnt_r[1] <= inc16[15:8];
				end
			end else begin
				if (!run_lo) cnt_r[0] <= 8'h00;
				else if (tick_lo && inc_lo == tt_r[0]) begin
					cnt_r[0] <= 8'h00;
					tmr_match_o[0] <= 1'b1;
				end else if (tick_lo) cnt_r[0] <= inc_lo;
				if (!run_up) cnt_r[1] <= 8'h00;
				else if (tick_up && inc_up == tt_r[1]) begin
					cnt_r[1] <= 8'h00;
					tmr_match_o[1] <= 1'b1;
				end else if (tick_up) cnt_r[1] <= inc_up;
			end
		end
	end
endmodule

// [cdt_ctrl_bench.sv]
// Self-checking bench for the cascaded timer controller
`timescale 1ns/1ps
module cdt_ctrl_bench;
	import cdt_pkg::*;
	logic ref_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [2:0] sw_addr = 3'h0;
	logic [15:0] sw_wdata = 16'h0000;
	logic sw_wr = 1'b0;
	logic sw_rd = 1'b0;
	logic [15:0] sw_rdata;
	logic [7:0] dev_addr;
	logic [7:0] dev_wdata;
	logic dev_wr;
	logic [1:0] tmr_match;
	logic [7:0] viol;
	logic [15:0] cap [$];
	int num_errors = 0;
	int cmp_count = 0;
	always #2.5 ref_clk_i = ~ref_clk_i;
	cdt_ctrl cdt_ctrl_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .sw_addr_i(sw_addr),
		.sw_wdata_i(sw_wdata), .sw_wr_i(sw_wr), .sw_rd_i(sw_rd), .sw_rdata_o(sw_rdata),
		.dev_addr_o(dev_addr), .dev_wdata_o(dev_wdata), .dev_wr_o(dev_wr),
		.tmr_match_i(tmr_match));
	cdt_dev_model cdt_dev_model_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
		.dev_addr_i(dev_addr), .dev_wdata_i(dev_wdata), .dev_wr_i(dev_wr),
		.tmr_match_o(tmr_match), .viol_o(viol));
	always @(posedge ref_clk_i) if (dev_wr === 1'b1) cap.push_back({dev_addr, dev_wdata});
	task summarize;
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge ref_clk_i);
		sw_addr <= a;
		sw_wdata <= d;
		sw_wr <= 1'b1;
		@(posedge ref_clk_i);
		sw_wr <= 1'b0;
	endtask
	task rd(input logic [2:0] a, output logic [15:0] d);
		@(posedge ref_clk_i);
		sw_addr <= a;
		sw_rd <= 1'b1;
		@(posedge ref_clk_i);
		sw_rd <= 1'b0;
		#1 d = sw_rdata;
	endtask
	task take(input logic [7:0] a, input logic [7:0] d);
		logic [15:0] g;
		g = (cap.size() > 0) ? cap.pop_front() : 16'hXXXX;
		chk(g, {a, d});
	endtask
	// Bounded poll on busy; a hang ends the run
	task wait_idle;
		logic [15:0] s;
		for (int i = 0; i < 40; i++) begin
			rd(SW_STATUS, s);
			if (s[0] === 1'b0) return;
		end
		chk(s, 16'h0000);
		summarize;
	endtask
	function automatic logic [15:0] cw(input logic go, input logic stop, input logic unit,
		input logic [2:0] mode, input logic [2:0] clk, input logic tff);
		return {6'h00, tff, clk, mode, unit, stop, go};
	endfunction
	task t_reset;
		logic [15:0] d;
		for (int a = 0; a < 8; a++) begin
			if (a == 1) wr(3'h7, 16'hFFFF);
			rd(a[2:0], d);
			chk(d, 16'h0000);
		end
	endtask
	task t_start8;
		logic [15:0] d;
		wr(SW_POWER, 16'h0000);
		wr(SW_PERIOD, 16'h0004);
		wr(SW_DUTY, 16'h0033);
		cap.delete();
		wr(SW_CMD, cw(1, 0, 0, MODE_TIMER, CLK_D8, 0));
		wait_idle;
		take(DEV_TT_LO, 8'h04);
		take(DEV_PW_LO, 8'h33);
		take(DEV_AUX, 8'h00);
		take(DEV_CTL_LO, {1'b0, CLK_D8, 1'b1, MODE_TIMER});
		rd(SW_STATUS, d);
		chk(d, 16'h0002);
		rd(SW_CMD, d);
		chk(d, cw(0, 0, 0, MODE_TIMER, CLK_D8, 0));
		wr(SW_MATCH, 16'h0000);
		repeat (40) @(posedge ref_clk_i);
		rd(SW_MATCH, d);
		chk({15'h0, d[7:0] >= 8'h09 && d[7:0] <= 8'h0B}, 16'h0001);
		wr(SW_PERIOD, 16'h0007);
		wr(SW_CMD, cw(1, 0, 0, MODE_TIMER, CLK_D8, 0));
		repeat (10) @(posedge ref_clk_i);
		chk(16'(cap.size()), 16'h0000);
		rd(SW_STATUS, d);
		chk(d, 16'h0082);
		wr(SW_STATUS, 16'h00F0);
		wr(SW_CMD, cw(0, 1, 0, MODE_PDO, CLK_HIGH, 1));
		wait_idle;
		take(DEV_CTL_LO, {1'b0, CLK_D8, 1'b0, MODE_TIMER});
		rd(SW_STATUS, d);
		chk(d, 16'h0000);
	endtask
	task bad_go(input logic [15:0] pw, input logic [15:0] per, input logic [15:0] du,
		input logic [15:0] cm, input logic [15:0] es);
		logic [15:0] d;
		wr(SW_POWER, pw);
		wr(SW_PERIOD, per);
		wr(SW_DUTY, du);
		cap.delete();
		wr(SW_CMD, cm);
		repeat (10) @(posedge ref_clk_i);
		rd(SW_STATUS, d);
		chk(d, es);
		chk(16'(cap.size()), 16'h0000);
		wr(SW_STATUS, 16'h00F0);
	endtask
	task t_wide;
		logic [15:0] d;
		wr(SW_POWER, 16'h0002);
		wr(SW_PERIOD, 16'h0102);
		wr(SW_DUTY, 16'h0001);
		cap.delete();
		wr(SW_CMD, cw(1, 0, 1, MODE_T16, CLK_D8, 0));
		wr(SW_MATCH, 16'h0000);
		wait_idle;
		take(DEV_TT_LO, 8'h02);
		take(DEV_TT_UP, 8'h01);
		take(DEV_PW_LO, 8'h01);
		take(DEV_PW_UP, 8'h00);
		take(DEV_AUX, AUX_SUPP_MASK);
		take(DEV_CTL_LO, {1'b0, CLK_D8, 1'b0, MODE_CASCADE});
		take(DEV_CTL_UP, {1'b0, CLK_D8, 1'b1, MODE_T16});
		rd(SW_STATUS, d);
		chk(d, 16'h000E);
		rd(SW_CMD, d);
		chk(d, cw(0, 0, 1, MODE_T16, CLK_D8, 0));
		repeat (600) @(posedge ref_clk_i);
		rd(SW_MATCH, d);
		chk({15'h0, d[15:8] >= 8'h01 && d[15:8] <= 8'h03 && d[7:0] == 8'h00}, 16'h0001);
		wr(SW_CMD, cw(0, 1, 1, MODE_T16, CLK_D8, 0));
		wait_idle;
		take(DEV_CTL_UP, {1'b0, CLK_D8, 1'b0, MODE_T16});
		wr(SW_POWER, 16'h0000);
	endtask
	initial begin
		repeat (12) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		@(posedge ref_clk_i);
		t_reset;
		t_start8;
		bad_go(16'h0, 16'h4, 16'h0, cw(1, 0, 0, MODE_TIMER, CLK_LOW, 0), 16'h10);
		bad_go(16'h1, 16'h4, 16'h0, cw(1, 0, 0, MODE_TIMER, CLK_D8, 0), 16'h10);
		bad_go(16'h0, 16'h0, 16'h0, cw(1, 0, 0, MODE_TIMER, CLK_D8, 0), 16'h20);
		bad_go(16'h0, 16'h4, 16'h1, cw(1, 0, 1, MODE_PWM, CLK_HIGH, 0), 16'h20);
		bad_go(16'h0, 16'h4, 16'h0, cw(1, 0, 0, MODE_TIMER, CLK_D8, 1), 16'h40);
		bad_go(16'h0, 16'hFF, 16'h0, cw(1, 0, 1, MODE_WARM, CLK_LOW, 0), 16'h20);
		bad_go(16'h0, 16'h9, 16'hFFFF, cw(1, 0, 1, MODE_PWM16, CLK_D8, 0), 16'h20);
		bad_go(16'h0, 16'h5, 16'h4, cw(1, 0, 1, MODE_PPG, CLK_D8, 0), 16'h20);
		bad_go(16'h1, 16'h4, 16'h0, cw(1, 0, 0, MODE_PDO, CLK_D8, 0), 16'h10);
		bad_go(16'h1, 16'h5, 16'h1, cw(1, 0, 1, MODE_PPG, CLK_LOW, 0), 16'h10);
		bad_go(16'h0, 16'h4, 16'h0, cw(1, 0, 0, MODE_CASCADE, CLK_D8, 0), 16'h30);
		t_wide;
		chk({8'h00, viol}, 16'h0000);
		summarize;
	end
endmodule
